// ---- core/rps_pkg.sv ----
// rps_pkg: shared constants, offsets and carrier types of the receive port status block.
// assumes an 8-bit register space with byte-wide data on the device's register clock.
package rps_pkg;
	// structure
	localparam int RPS_PORTS = 2;
	localparam int RPS_CNT_W = 16;
	// register offsets
	localparam logic [7:0] RPS_OFS_PORT_SEL = 8'h4c;
	localparam logic [7:0] RPS_OFS_STS_ONE = 8'h4d;
	localparam logic [7:0] RPS_OFS_STS_TWO = 8'h4e;
	localparam logic [7:0] RPS_OFS_PAR_HI = 8'h55;
	localparam logic [7:0] RPS_OFS_PAR_LO = 8'h56;
	localparam logic [7:0] RPS_OFS_PAR_THR = 8'h57;
	localparam logic [7:0] RPS_OFS_PASS_CTL = 8'h58;
	// port select fields
	localparam int RPS_SEL_WR0 = 0;
	localparam int RPS_SEL_RD = 4;
	localparam int RPS_SEL_PHYS = 6;
	localparam logic [7:0] RPS_SEL_WMASK = 8'h1f;
	localparam logic [7:0] RPS_SEL_RST = 8'h00;
	// status one fields
	localparam int RPS_STS_LOCK = 0;
	localparam int RPS_STS_PASS = 1;
	localparam int RPS_STS_PAR = 2;
	localparam int RPS_STS_SEQ = 3;
	localparam int RPS_STS_CHG = 4;
	localparam int RPS_STS_CRC = 5;
	localparam int RPS_STS_PORT = 6;
	// pass control fields and reset values
	localparam int RPS_PCTL_LOCK = 0;
	localparam int RPS_PCTL_PAR = 1;
	localparam logic [7:0] RPS_PCTL_RST = 8'h01;
	localparam logic [7:0] RPS_THR_RST = 8'h01;
	localparam logic [7:0] RPS_ZERO = 8'h00;
	localparam logic [RPS_CNT_W-1:0] RPS_CNT_ZERO = 16'h0000;
	localparam logic [RPS_CNT_W-1:0] RPS_CNT_ONE = 16'h0001;
	localparam logic [RPS_CNT_W-1:0] RPS_CNT_MAX = 16'hffff;

	// one register access from the local bus or the control channel
	typedef struct packed
	{
		logic valid;
		logic write;
		logic from_channel;
		logic channel_port;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rps_acc_s;

	// receiver event pulses of one port
	typedef struct packed
	{
		logic crc_err;
		logic seq_err;
		logic par_err;
	} rps_evt_s;

	// registered state of one port
	typedef struct packed
	{
		logic lock;
		logic pass;
		logic par_flag;
		logic seq_flag;
		logic chg_flag;
		logic crc_flag;
		logic [RPS_CNT_W-1:0] count;
		logic [7:0] thr;
		logic [7:0] pctl;
	} rps_port_s;
endpackage : rps_pkg

// ---- core/rps_port_status.sv ----
// rps_port_status: flags, parity counter, threshold and pass control of one receive port.
// assumes lock is already synchronised and event pulses come from logic on clk.
`timescale 1ns/100ps
module rps_port_status
	import rps_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic lock,
	input rps_evt_s ev,
	input wire logic wr_thr,
	input wire logic wr_pctl,
	input wire logic [7:0] wdata,
	input wire logic rd_clr_sts,
	input wire logic rd_clr_cnt,
	output rps_port_s st
);
	rps_port_s st_d;
	rps_port_s st_q;
	logic cnt_clr;

	// next state of the port
	always_comb
	begin
		st_d = st_q;
		st_d.lock = lock;
		// counter clears on a low byte read or when lock is newly gained
		cnt_clr = rd_clr_cnt | (lock & ~st_q.lock);
		if (cnt_clr)
			st_d.count = RPS_CNT_ZERO;
		else if (ev.par_err && lock && st_q.count != RPS_CNT_MAX)
			st_d.count = st_q.count + RPS_CNT_ONE;
		if (cnt_clr)
			st_d.par_flag = 1'b0;
		else if (st_q.count > RPS_CNT_W'(st_q.thr))
			st_d.par_flag = 1'b1;
		st_d.crc_flag = ev.crc_err | (st_q.crc_flag & ~rd_clr_sts);
		st_d.seq_flag = ev.seq_err | (st_q.seq_flag & ~rd_clr_sts);
		st_d.chg_flag = (lock ^ st_q.lock) | (st_q.chg_flag & ~rd_clr_sts);
		st_d.pass = (~st_q.pctl[RPS_PCTL_LOCK] | st_q.lock) & (~st_q.pctl[RPS_PCTL_PAR] | ~st_q.par_flag);
		if (wr_thr)
			st_d.thr = wdata;
		if (wr_pctl)
			st_d.pctl = wdata;
	end

	// port state registers
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st_q <= '0;
			st_q.thr <= RPS_THR_RST;
			st_q.pctl <= RPS_PCTL_RST;
		end
		else
			st_q <= st_d;
	end

	assign st = st_q;
endmodule : rps_port_status

// ---- core/rps_status_regs.sv ----
// rps_status_regs: port select and paged status registers for two receive ports.
// assumes one access at a time on acc, answered one cycle later; lock pins are asynchronous.
`timescale 1ns/100ps
// Functional notes
// - writes to port 1 paged registers only when its write enable bit 1 is set.
// - writes to port 0 paged registers only when its write enable bit 0 is set.
// - with both enables set, one write lands in both ports' paged registers.
// - channel access defaults the carrying port's write enable to 1; local default 0.
// - status bit 6 returns the currently selected read port number.
// - bit 5 latches control channel crc error; cleared by status read.
// - bit 4 latches any lock change since last status read; cleared on read.
// - bit 3 latches control channel sequence error; cleared by status read.
// - bit 2 sets when parity error count exceeds the programmed threshold.
// - parity threshold flag clears with the parity counters, not on status read.
// - bit 1 shows live pass state per pass criteria control register.
// - bit 0 shows live receiver lock state.
// - select bit 4 picks which port's paged registers are read back.
// - parity counters accumulate since lock or low byte read; low byte read clears.
module rps_status_regs
	import rps_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input rps_acc_s acc,
	input wire logic [RPS_PORTS-1:0] lock_pin,
	input rps_evt_s [RPS_PORTS-1:0] rx_ev,
	output logic rd_ack,
	output logic [7:0] rd_data
);
	logic [RPS_PORTS-1:0] lock_meta_q;
	logic [RPS_PORTS-1:0] lock_sync_q;
	logic [7:0] loc_sel_q, loc_sel_d;
	logic [7:0] chn_sel_q, chn_sel_d;
	logic chn_vld_q, chn_vld_d;
	logic [7:0] cur_sel;
	logic rp;
	logic [RPS_PORTS-1:0] wr_thr, wr_pctl, rd_clr_sts, rd_clr_cnt;
	rps_port_s [RPS_PORTS-1:0] st;
	logic [7:0] rdata_d, rdata_q;
	logic ack_d, ack_q;
	logic sel_wr;

	// write enable bit of one port within a select value
	function automatic logic port_wr_en(input logic [7:0] sel, input int p);
		port_wr_en = sel[RPS_SEL_WR0 + p];
	endfunction : port_wr_en

	// defaults seen by a channel access
	function automatic logic [7:0] chan_default(input logic port);
		logic [7:0] v;
		v = RPS_ZERO;
		v[RPS_SEL_WR0 + int'(port)] = 1'b1;
		v[RPS_SEL_RD] = port;
		chan_default = v;
	endfunction : chan_default

	// lock pins pass two flip-flops
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			lock_meta_q <= '0;
			lock_sync_q <= '0;
		end
		else
		begin
			lock_meta_q <= lock_pin;
			lock_sync_q <= lock_meta_q;
		end
	end

	// select value in force for this access and its decodes
	always_comb
	begin
		// local keeps its own, channel starts from its defaults
		if (acc.from_channel)
			cur_sel = chn_vld_q ? chn_sel_q : chan_default(acc.channel_port);
		else
			cur_sel = loc_sel_q;
		rp = cur_sel[RPS_SEL_RD];
		sel_wr = acc.valid & acc.write & (acc.addr == RPS_OFS_PORT_SEL);
	end

	// per-port strobes and port instances
	generate
		for (genvar p = 0; p < RPS_PORTS; p++)
		begin : g_port
			assign wr_thr[p] = acc.valid & acc.write & (acc.addr == RPS_OFS_PAR_THR) & port_wr_en(cur_sel, p);
			assign wr_pctl[p] = acc.valid & acc.write & (acc.addr == RPS_OFS_PASS_CTL) & port_wr_en(cur_sel, p);
			// clear on status one read or parity low byte read of the selected port
			assign rd_clr_sts[p] = acc.valid & ~acc.write & (acc.addr == RPS_OFS_STS_ONE) & (int'(rp) == p);
			assign rd_clr_cnt[p] = acc.valid & ~acc.write & (acc.addr == RPS_OFS_PAR_LO) & (int'(rp) == p);
			rps_port_status u_port
			(
				.clk(clk),
				.reset_n(reset_n),
				.lock(lock_sync_q[p]),
				.ev(rx_ev[p]),
				.wr_thr(wr_thr[p]),
				.wr_pctl(wr_pctl[p]),
				.wdata(acc.wdata),
				.rd_clr_sts(rd_clr_sts[p]),
				.rd_clr_cnt(rd_clr_cnt[p]),
				.st(st[p])
			);
		end
	endgenerate

	// select registers and read data
	always_comb
	begin
		loc_sel_d = loc_sel_q;
		chn_sel_d = chn_sel_q;
		chn_vld_d = chn_vld_q;
		// only the writable select bits are stored
		if (sel_wr && acc.from_channel)
		begin
			chn_sel_d = acc.wdata & RPS_SEL_WMASK;
			chn_vld_d = 1'b1;
		end
		else if (sel_wr)
			loc_sel_d = acc.wdata & RPS_SEL_WMASK;
		ack_d = acc.valid;
		rdata_d = RPS_ZERO;
		if (acc.valid && !acc.write)
		begin
			case (acc.addr)
				RPS_OFS_PORT_SEL:
				begin
					rdata_d = cur_sel;
					rdata_d[RPS_SEL_PHYS] = acc.from_channel & acc.channel_port;
				end
				RPS_OFS_STS_ONE:
				begin
					rdata_d[RPS_STS_LOCK] = st[rp].lock;
					rdata_d[RPS_STS_PASS] = st[rp].pass;
					rdata_d[RPS_STS_PAR] = st[rp].par_flag;
					rdata_d[RPS_STS_SEQ] = st[rp].seq_flag;
					rdata_d[RPS_STS_CHG] = st[rp].chg_flag;
					rdata_d[RPS_STS_CRC] = st[rp].crc_flag;
					rdata_d[RPS_STS_PORT] = rp;
				end
				RPS_OFS_PAR_HI: rdata_d = st[rp].count[RPS_CNT_W-1:8];
				RPS_OFS_PAR_LO: rdata_d = st[rp].count[7:0];
				RPS_OFS_PAR_THR: rdata_d = st[rp].thr;
				RPS_OFS_PASS_CTL: rdata_d = st[rp].pctl;
				default: rdata_d = RPS_ZERO;
			endcase
		end
	end

	// register stage of select state and answer
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			loc_sel_q <= RPS_SEL_RST;
			chn_sel_q <= RPS_SEL_RST;
			chn_vld_q <= 1'b0;
			rdata_q <= RPS_ZERO;
			ack_q <= 1'b0;
		end
		else
		begin
			loc_sel_q <= loc_sel_d;
			chn_sel_q <= chn_sel_d;
			chn_vld_q <= chn_vld_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	assign rd_ack = ack_q;
	assign rd_data = rdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// status read of one port with no new crc event
	sequence s_sts_read0;
		rd_clr_sts[0] && !rx_ev[0].crc_err;
	endsequence

	AST_WR_BLOCK_P1: assert property (wr_thr[1] == 1'b0 && !wr_pctl[1] |=> $stable(st[1].thr))
		else $error("port 1 threshold changed without write enable");
	AST_WR_BLOCK_P0: assert property (acc.valid && acc.write && !port_wr_en(cur_sel, 0) |=> $stable(st[0].thr))
		else $error("port 0 threshold changed without write enable");
	AST_WR_BOTH: assert property (wr_thr[0] && wr_thr[1] |=> st[0].thr == $past(acc.wdata) && st[1].thr == st[0].thr)
		else $error("dual write did not reach both ports");
	AST_CHAN_DEFAULT: assert property (acc.valid && acc.write && acc.from_channel && acc.channel_port && !chn_vld_q
		&& acc.addr == RPS_OFS_PAR_THR |=> st[1].thr == $past(acc.wdata))
		else $error("channel access lacks its default write enable");
	AST_PORT_NUM: assert property (acc.valid && !acc.write && acc.addr == RPS_OFS_STS_ONE |=> rd_ack && rd_data[RPS_STS_PORT] == $past(rp))
		else $error("status port number wrong");
	AST_CRC_CLR: assert property (s_sts_read0 |=> !st[0].crc_flag)
		else $error("crc flag not cleared by read");
	AST_CRC_SET: assert property (rx_ev[0].crc_err |=> st[0].crc_flag)
		else $error("crc event lost");
	AST_LOCK_CHG: assert property (st[0].lock != $past(st[0].lock) |-> st[0].chg_flag)
		else $error("lock change not flagged");
	AST_PAR_THR: assert property (st[0].count > 16'(st[0].thr) && !rd_clr_cnt[0] && !(lock_sync_q[0] && !st[0].lock)
		|=> st[0].par_flag)
		else $error("parity flag missed threshold");
	AST_PAR_CLR: assert property (rd_clr_cnt[0] |=> !st[0].par_flag && st[0].count == RPS_CNT_ZERO)
		else $error("parity flag not cleared with counter");
	// only once the whole synchroniser path has been out of reset
	AST_LOCK_LIVE: assert property ($past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3)
		|-> st[0].lock == $past(lock_pin[0], 3))
		else $error("lock bit does not follow pin");
	AST_RO_STS: assert property (acc.valid && acc.write && acc.addr == RPS_OFS_STS_ONE
		|=> $stable(loc_sel_q) && $stable(chn_sel_q) && $stable(st[0].pctl))
		else $error("write to status register had an effect");

	// status one read request
	sequence s_sts_one_read;
		acc.valid && !acc.write && acc.addr == RPS_OFS_STS_ONE;
	endsequence

	AST_SEQ_SET: assert property (rx_ev[0].seq_err |=> st[0].seq_flag)
		else $error("sequence event lost");
	AST_PASS_LOCK: assert property (st[0].pctl[RPS_PCTL_LOCK] && !st[0].lock |=> !st[0].pass)
		else $error("pass shown without lock");
	AST_PASS_PAR: assert property (st[0].pctl[RPS_PCTL_PAR] && st[0].par_flag |=> !st[0].pass)
		else $error("pass shown with parity flag set");
	AST_RSV_ZERO: assert property (s_sts_one_read |=> rd_data[7] == 1'b0)
		else $error("reserved status bit not zero");
	AST_STS_TWO: assert property (acc.valid && !acc.write && acc.addr == RPS_OFS_STS_TWO
		|=> rd_ack && rd_data == RPS_ZERO)
		else $error("out of scope status register not zero");
endmodule : rps_status_regs

// ---- test/rps_link_model.sv ----
// rps_link_model: far-end receiver model giving lock levels and event pulses.
// assumes requests change at the falling edge of clk.
`timescale 1ns/100ps
module rps_link_model
	import rps_pkg::*;
(
	input wire logic clk,
	input wire logic [RPS_PORTS-1:0] lock_req,
	input rps_evt_s [RPS_PORTS-1:0] ev_req,
	output logic [RPS_PORTS-1:0] lock_pin,
	output rps_evt_s [RPS_PORTS-1:0] rx_ev
);
	// launch on the rising edge so each event is one whole cycle
	always_ff @(posedge clk)
	begin
		lock_pin <= lock_req;
		rx_ev <= ev_req;
	end
endmodule : rps_link_model

// ---- test/rx_port_status_and_write_select_bench.sv ----
// bench for rps_status_regs: register accesses, link events and lock changes.
// assumes one access at a time, answered one cycle after it is taken.
`timescale 1ns/100ps
module rx_port_status_and_write_select_bench;
	import rps_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	rps_acc_s acc = '0;
	logic [1:0] lock_req = 2'h0;
	rps_evt_s [1:0] ev_req = '0;
	logic [1:0] lock_pin;
	rps_evt_s [1:0] rx_ev;
	logic rd_ack;
	logic [7:0] rd_data;
	int failures = 0;
	int n_compared = 0;

	rps_status_regs dut_u (.clk(clk), .reset_n(reset_n), .acc(acc), .lock_pin(lock_pin), .rx_ev(rx_ev),
		.rd_ack(rd_ack), .rd_data(rd_data));
	rps_link_model link_u (.clk(clk), .lock_req(lock_req), .ev_req(ev_req), .lock_pin(lock_pin), .rx_ev(rx_ev));

	// 50 ns clock
	initial
	begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one access; channel accesses come in over port 1
	task automatic acc_op(input logic w, input logic ch, input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] e);
		@(negedge clk);
		acc = '{valid: 1'b1, write: w, from_channel: ch, channel_port: ch, addr: a, wdata: d};
		@(negedge clk);
		acc = '0;
		chk("rd_ack", 8'h01, {7'h00, rd_ack});
		chk("rd_data", e, rd_data);
	endtask : acc_op

	task automatic ev(input int p, input logic [2:0] e);
		@(negedge clk);
		ev_req[p] = rps_evt_s'(e);
		@(negedge clk);
		ev_req[p] = '0;
	endtask : ev

	task automatic t_reset;
		acc_op(0, 0, 8'h4d, 8'h00, 8'h00);
		acc_op(0, 0, 8'h4c, 8'h00, 8'h00);
	endtask : t_reset

	task automatic t_lock;
		lock_req = 2'h1;
		repeat (6) @(negedge clk);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h13);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h03);
	endtask : t_lock

	task automatic t_flags;
		ev(0, 3'h4);
		ev(0, 3'h2);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h2b);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h03);
	endtask : t_flags

	task automatic t_wsel;
		acc_op(1, 0, 8'h57, 8'h09, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h01);
		acc_op(1, 0, 8'h4c, 8'h03, 8'h00);
		acc_op(1, 0, 8'h57, 8'h02, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h02);
		acc_op(1, 0, 8'h4c, 8'h12, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h02);
		acc_op(1, 0, 8'h57, 8'h05, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h05);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h40);
		acc_op(1, 0, 8'h4c, 8'h11, 8'h00);
		acc_op(1, 0, 8'h57, 8'h02, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h05);
		acc_op(1, 0, 8'h4c, 8'h02, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h02);
	endtask : t_wsel

	task automatic t_parity;
		acc_op(1, 0, 8'h4c, 8'h01, 8'h00);
		acc_op(1, 0, 8'h58, 8'h03, 8'h00);
		acc_op(0, 0, 8'h58, 8'h00, 8'h03);
		repeat (3) ev(0, 3'h1);
		repeat (3) @(negedge clk);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h05);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h05);
		acc_op(0, 0, 8'h55, 8'h00, 8'h00);
		acc_op(0, 0, 8'h56, 8'h00, 8'h03);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h03);
	endtask : t_parity

	task automatic t_chan;
		acc_op(0, 1, 8'h4c, 8'h00, 8'h52);
		acc_op(1, 1, 8'h57, 8'h0a, 8'h00);
		acc_op(1, 0, 8'h4c, 8'h10, 8'h00);
		acc_op(0, 0, 8'h57, 8'h00, 8'h0a);
		acc_op(1, 0, 8'h4c, 8'h00, 8'h00);
	endtask : t_chan

	task automatic t_ro;
		acc_op(1, 0, 8'h4d, 8'hff, 8'h00);
		acc_op(0, 0, 8'h4d, 8'h00, 8'h03);
		acc_op(0, 0, 8'h4e, 8'h00, 8'h00);
		acc_op(0, 0, 8'h60, 8'h00, 8'h00);
	endtask : t_ro

	task automatic complete_run;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	// main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		t_reset();
		t_lock();
		t_flags();
		t_wsel();
		t_parity();
		t_chan();
		t_ro();
		complete_run();
	end

	// watchdog well beyond the expected run
	initial
	begin
		#1000000;
		failures++;
		complete_run();
	end
endmodule : rx_port_status_and_write_select_bench
